// File: rtl/pt_edge_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
module pt_edge_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic din,
	output logic      rise,
	output logic      fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;
	logic rise_q;
	logic fall_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lvl_q  <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
			fall_q <= (s2_q == s3_q) && !s3_q && lvl_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end

	assign rise = rise_q;
	assign fall = fall_q;
endmodule

// File: rtl/pt_pkg.sv
// constants, register map and carrier types of the periodic timer
package pt_pkg;

	localparam int          PT_CNT_W     = 16;
	localparam int          PT_ADR_W     = 6;

	// register byte addresses, one 32-bit word each
	localparam logic [5:0]  PT_ADR_CTRL0 = 6'h00;
	localparam logic [5:0]  PT_ADR_CTRL1 = 6'h04;
	localparam logic [5:0]  PT_ADR_CNTL  = 6'h08;
	localparam logic [5:0]  PT_ADR_CNTH  = 6'h0c;
	localparam logic [5:0]  PT_ADR_CMPAL = 6'h10;
	localparam logic [5:0]  PT_ADR_CMPAH = 6'h14;
	localparam logic [5:0]  PT_ADR_PERL  = 6'h18;
	localparam logic [5:0]  PT_ADR_PERH  = 6'h1c;
	localparam logic [5:0]  PT_ADR_FLAGS = 6'h20;

	// field positions
	localparam int          PT_C0_HOLD   = 7;
	localparam int          PT_C0_CKS    = 4;
	localparam int          PT_C0_ON     = 3;
	localparam int          PT_C1_MODE   = 6;
	localparam int          PT_C1_IO     = 4;
	localparam int          PT_C1_OC     = 3;
	localparam int          PT_C1_INV    = 2;
	localparam int          PT_C1_CCL    = 0;
	localparam int          PT_FL_A      = 0;
	localparam int          PT_FL_P      = 1;

	// reset values
	localparam logic [7:0]  PT_CTRL_RST  = 8'h00;
	localparam logic [15:0] PT_VAL_RST   = 16'h0000;
	localparam logic [1:0]  PT_FL_RST    = 2'h0;

	// counter limits for the two widths
	localparam logic [15:0] PT_MAX10     = 16'h03ff;
	localparam logic [15:0] PT_MAX16     = 16'hffff;

	// prescaler tap masks
	localparam logic [5:0]  PT_DIV4      = 6'h03;
	localparam logic [5:0]  PT_DIV16     = 6'h0f;
	localparam logic [5:0]  PT_DIV64     = 6'h3f;

	// clock source codes
	localparam logic [2:0]  PT_CK_SYS4   = 3'h0;
	localparam logic [2:0]  PT_CK_SYS    = 3'h1;
	localparam logic [2:0]  PT_CK_H16    = 3'h2;
	localparam logic [2:0]  PT_CK_H64    = 3'h3;
	localparam logic [2:0]  PT_CK_SUB0   = 3'h4;
	localparam logic [2:0]  PT_CK_SUB1   = 3'h5;
	localparam logic [2:0]  PT_CK_ERISE  = 3'h6;
	localparam logic [2:0]  PT_CK_EFALL  = 3'h7;

	// pin function codes, meaning depends on mode
	localparam logic [1:0]  PT_IO_00     = 2'h0;
	localparam logic [1:0]  PT_IO_01     = 2'h1;
	localparam logic [1:0]  PT_IO_10     = 2'h2;
	localparam logic [1:0]  PT_IO_11     = 2'h3;

	typedef enum logic [1:0] {
		PT_MODE_CMP   = 2'h0,
		PT_MODE_UNDEF = 2'h1,
		PT_MODE_PWM   = 2'h2,
		PT_MODE_TMR   = 2'h3
	} pt_mode_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [5:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pt_wb_req_t;

endpackage

// File: rtl/pt_timer.sv
// periodic timer: up-counter, two comparators, output pin logic, wishbone registers
//
// Contract
// - up-counter of 10 or 16 bits advancing on each selected clock tick
// - comparators A and P compare full counter width continuously
// - software cannot write counter; software clears it only through a counter-on rising edge
// - overflow or associated compare match clears counter; only compare matches raise a flag, overflow raises none
// - hold bit freezes counter; clearing it resumes from held value
// - clock select picks system/4, system, high/16, high/64, sub, pin edges
// - counter-on runs counter; off retains value; rising edge zeroes it
// - counter-on rising restores pin initial level in compare output mode
// - mode field: compare output, undefined, pwm or single pulse, timer
// - timer mode leaves pin undriven; pin function unused
// - compare mode A match: keep, drive low, drive high or toggle
// - pwm modes: force inactive, force active, pwm wave, single pulse
// - compare mode request equal to initial level gives no visible change
// - counter readable read-only; compare A and period read/write pairs
// - low three bits of control register zero read as zero
// - initial level bit: compare start level, pwm active polarity
// - invert bit inverts pin level; no effect in timer mode
// - clear select: A match when 1 outside pwm mode, else P match or overflow when P zero; single pulse never clears
module pt_timer #(
	parameter bit WIDE16 = 1'b1
) (
	input  wire logic                CLK,
	input  wire logic                RST,
	input  wire pt_pkg::pt_wb_req_t  WB_REQ,
	output logic [31:0]              WB_DAT_O,
	output logic                     WB_ACK_O,
	input  wire logic                EXT_CLOCK_PIN,
	input  wire logic                SUB_CLOCK,
	output logic                     TIMER_OUT,
	output logic                     TIMER_OUT_EN
);
	import pt_pkg::*;

	logic [7:0]      ctrl0_q;
	logic [7:0]      ctrl1_q;
	logic [15:0]     cnt_q;
	logic [15:0]     cnt_d;
	logic [15:0]     cmp_a_q;
	logic [15:0]     cmp_p_q;
	logic [1:0]      flags_q;
	logic [1:0]      flags_d;
	logic [5:0]      div_q;
	logic            ack_q;
	logic [31:0]     dat_q;
	logic            pin_q;
	logic            out_q;
	logic            oe_q;
	logic            on_d;
	logic            on_rise;
	logic            tick;
	logic [7:0]      rdata;
	logic [1:0]      pin_in;
	logic [1:0]      pin_rise;
	logic [1:0]      pin_fall;
	logic            clr_auto;
	logic            pwm_active;

	wire             req      = WB_REQ.cyc & WB_REQ.stb;
	wire             wr_en    = req & ack_q & WB_REQ.we & WB_REQ.sel[0];
	wire [7:0]       wdat     = WB_REQ.dat[7:0];
	wire             hold     = ctrl0_q[PT_C0_HOLD];
	wire [2:0]       cks      = ctrl0_q[PT_C0_CKS +: 3];
	wire             on_q     = ctrl0_q[PT_C0_ON];
	wire pt_mode_t   mode     = pt_mode_t'(ctrl1_q[PT_C1_MODE +: 2]);
	wire [1:0]       io       = ctrl1_q[PT_C1_IO +: 2];
	wire             oc       = ctrl1_q[PT_C1_OC];
	wire             inv      = ctrl1_q[PT_C1_INV];
	wire             ccl      = ctrl1_q[PT_C1_CCL];
	wire             pulse_md = (mode == PT_MODE_PWM) && (io == PT_IO_11);
	// limit a value to the instance width
	function automatic logic [15:0] width_mask(input logic [15:0] v);
		return WIDE16 ? v : (v & PT_MAX10);
	endfunction
	// register write strobe for one address
	function automatic logic wr_hit(input logic [5:0] a);
		return wr_en && (WB_REQ.adr == a);
	endfunction

	wire [15:0]      cnt_max  = width_mask(PT_MAX16);
	wire             step     = on_q && !hold && tick;
	wire             a_hit    = step && (cnt_q == cmp_a_q);
	wire             p_hit    = step && (cnt_q == cmp_p_q) && (cmp_p_q != PT_VAL_RST);
	wire             ovf      = step && (cnt_q == cnt_max);
	// sub clock and external pin cross into the system clock domain
	assign pin_in = {SUB_CLOCK, EXT_CLOCK_PIN};
	generate
		for (genvar i = 0; i < 2; i++) begin : g_sync
			pt_edge_sync u_sync (
				.clk  (CLK),
				.rst  (RST),
				.din  (pin_in[i]),
				.rise (pin_rise[i]),
				.fall (pin_fall[i])
			);
		end
	endgenerate
	// free-running prescaler; high clock is the system clock here
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			div_q <= 6'h00;
		end else begin
			div_q <= 6'(div_q + 6'h01);
		end
	end
	always_comb begin
		case (cks)
			PT_CK_SYS4:  tick = (div_q & PT_DIV4) == PT_DIV4;
			PT_CK_SYS:   tick = 1'b1;
			PT_CK_H16:   tick = (div_q & PT_DIV16) == PT_DIV16;
			PT_CK_H64:   tick = div_q == PT_DIV64;
			PT_CK_SUB0,
			PT_CK_SUB1:  tick = pin_rise[1];
			PT_CK_ERISE: tick = pin_rise[0];
			PT_CK_EFALL: tick = pin_fall[0];
			default:     tick = 1'b0;
		endcase
	end
	// counter-on: software write wins, pulse end and pin trigger below it
	always_comb begin
		on_d = on_q;
		if (pulse_md && a_hit) begin
			on_d = 1'b0;
		end
		if (pulse_md && !on_q && ((cks == PT_CK_EFALL) ? pin_fall[0] : pin_rise[0])) begin
			on_d = 1'b1;
		end
		if (wr_hit(PT_ADR_CTRL0)) begin
			on_d = wdat[PT_C0_ON];
		end
	end
	assign on_rise = on_d & ~on_q;
	always_comb begin
		if (mode == PT_MODE_PWM) begin
			clr_auto = !pulse_md && (p_hit || (cmp_p_q == PT_VAL_RST && ovf));
		end else if (ccl) begin
			clr_auto = a_hit;
		end else begin
			clr_auto = p_hit || (cmp_p_q == PT_VAL_RST && ovf);
		end
	end
	always_comb begin
		cnt_d = cnt_q;
		if (on_rise) begin
			cnt_d = PT_VAL_RST;
		end else if (step) begin
			cnt_d = clr_auto ? PT_VAL_RST : width_mask(16'(cnt_q + 16'h0001));
		end
	end
	// hold and off retain the value
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cnt_q <= PT_VAL_RST;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// match flags, set wins over clear
	always_comb begin
		flags_d = flags_q;
		if (wr_hit(PT_ADR_FLAGS)) begin
			flags_d = flags_q & ~wdat[1:0];
		end
		if (a_hit && cmp_a_q != PT_VAL_RST) begin
			flags_d[PT_FL_A] = 1'b1;
		end
		if (p_hit && !(ccl && mode != PT_MODE_PWM) && !pulse_md) begin
			flags_d[PT_FL_P] = 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			flags_q <= PT_FL_RST;
		end else begin
			flags_q <= flags_d;
		end
	end
	// control registers; low bits of the first stay zero
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl0_q <= PT_CTRL_RST;
			ctrl1_q <= PT_CTRL_RST;
		end else begin
			ctrl0_q <= {(wr_hit(PT_ADR_CTRL0) ? wdat[7:4] : ctrl0_q[7:4]), on_d, 3'b000};
			if (wr_hit(PT_ADR_CTRL1)) begin
				ctrl1_q <= wdat;
			end
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cmp_a_q <= PT_VAL_RST;
			cmp_p_q <= PT_VAL_RST;
		end else begin
			if (wr_hit(PT_ADR_CMPAL)) begin
				cmp_a_q <= {cmp_a_q[15:8], wdat};
			end
			if (wr_hit(PT_ADR_CMPAH)) begin
				cmp_a_q <= width_mask({wdat, cmp_a_q[7:0]});
			end
			if (wr_hit(PT_ADR_PERL)) begin
				cmp_p_q <= {cmp_p_q[15:8], wdat};
			end
			if (wr_hit(PT_ADR_PERH)) begin
				cmp_p_q <= width_mask({wdat, cmp_p_q[7:0]});
			end
		end
	end
	// initial level on start, compare match action
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pin_q <= 1'b0;
		end else if (on_rise) begin
			pin_q <= oc;
		end else if (mode == PT_MODE_CMP && a_hit) begin
			case (io)
				PT_IO_01: pin_q <= 1'b0;
				PT_IO_10: pin_q <= 1'b1;
				PT_IO_11: pin_q <= ~pin_q;
				default:  pin_q <= pin_q;
			endcase
		end
	end
	always_comb begin
		case (io)
			PT_IO_00: pwm_active = 1'b0;
			PT_IO_01: pwm_active = 1'b1;
			PT_IO_10: pwm_active = on_q && (cnt_q < cmp_a_q);
			default:  pwm_active = on_q;
		endcase
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			out_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			case (mode)
				PT_MODE_CMP: begin
					out_q <= pin_q ^ inv;
					oe_q  <= 1'b1;
				end
				PT_MODE_PWM: begin
					out_q <= (oc ? pwm_active : ~pwm_active) ^ inv;
					oe_q  <= 1'b1;
				end
				default: begin
					out_q <= 1'b0;
					oe_q  <= 1'b0;
				end
			endcase
		end
	end
	// read mux; counter is read only
	always_comb begin
		case (WB_REQ.adr)
			PT_ADR_CTRL0: rdata = ctrl0_q;
			PT_ADR_CTRL1: rdata = ctrl1_q;
			PT_ADR_CNTL:  rdata = cnt_q[7:0];
			PT_ADR_CNTH:  rdata = cnt_q[15:8];
			PT_ADR_CMPAL: rdata = cmp_a_q[7:0];
			PT_ADR_CMPAH: rdata = cmp_a_q[15:8];
			PT_ADR_PERL:  rdata = cmp_p_q[7:0];
			PT_ADR_PERH:  rdata = cmp_p_q[15:8];
			PT_ADR_FLAGS: rdata = {6'h00, flags_q};
			default:      rdata = 8'h00;
		endcase
	end
	// one-cycle wishbone answer, writes land on the ack edge
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= req & ~ack_q;
			if (req && !ack_q) begin
				dat_q <= {24'h000000, rdata};
			end
		end
	end

	assign WB_DAT_O     = dat_q;
	assign WB_ACK_O     = ack_q;
	assign TIMER_OUT    = out_q;
	assign TIMER_OUT_EN = oe_q;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_start;
		on_rise;
	endsequence
	sequence s_zeroed;
		cnt_q == PT_VAL_RST;
	endsequence
	property p_start_clear;
		s_start |=> s_zeroed;
	endproperty
	a_start_clear: assert property (p_start_clear)
		else $error("counter not zeroed on start");
	property p_hold_freeze;
		(on_q && hold && !on_rise) |=> (cnt_q == $past(cnt_q));
	endproperty
	a_hold_freeze: assert property (p_hold_freeze)
		else $error("counter moved while held");
	property p_off_retain;
		(!on_q && !on_d)[*2] |-> $stable(cnt_q);
	endproperty
	a_off_retain: assert property (p_off_retain)
		else $error("counter moved while off");
	property p_ctrl0_low_zero;
		(req && !ack_q && WB_REQ.adr == PT_ADR_CTRL0) |=> (WB_ACK_O && WB_DAT_O[2:0] == 3'b000);
	endproperty
	a_ctrl0_low_zero: assert property (p_ctrl0_low_zero)
		else $error("unused control bits read nonzero");
	property p_a_clear;
		(mode == PT_MODE_CMP && ccl && a_hit && !on_rise) |=> s_zeroed;
	endproperty
	a_a_clear: assert property (p_a_clear)
		else $error("compare A match did not clear counter");
	property p_pin_init;
		(s_start and (mode == PT_MODE_CMP)) |=> (pin_q == $past(oc)) ##1 (TIMER_OUT == (pin_q ^ inv));
	endproperty
	a_pin_init: assert property (p_pin_init)
		else $error("pin not at initial level after start");
	property p_toggle;
		(mode == PT_MODE_CMP && a_hit && io == PT_IO_11 && !on_rise) |=> (pin_q != $past(pin_q));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("toggle action missing");
	property p_pulse_end;
		(pulse_md && a_hit && !wr_hit(PT_ADR_CTRL0)) |=> !on_q;
	endproperty
	a_pulse_end: assert property (p_pulse_end)
		else $error("single pulse not ended by A match");
	property p_p_flag;
		(mode != PT_MODE_PWM && !ccl && p_hit) |=> flags_q[PT_FL_P];
	endproperty
	a_p_flag: assert property (p_p_flag)
		else $error("period match flag not raised");
	property p_timer_undriven;
		(mode == PT_MODE_TMR) |=> !TIMER_OUT_EN;
	endproperty
	a_timer_undriven: assert property (p_timer_undriven)
		else $error("pin driven in timer mode");

endmodule

// File: tb/periodic_timer_module_test.sv
// self-checking bench of the periodic timer
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("FAIL %s expected %h seen %h", nm, e, g); end end
module periodic_timer_module_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pt_pkg::*;

	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	pt_wb_req_t  req = '0;
	logic [31:0] dat_o;
	logic        ack;
	logic        tout;
	logic        ten;
	logic        ext_pin;
	logic        sub_clk;
	logic        pin_wire;
	int          mismatches = 0;
	int          n_checks = 0;

	always #20 CLK = ~CLK;

	pt_timer dut (.CLK(CLK), .RST(RST), .WB_REQ(req), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.EXT_CLOCK_PIN(ext_pin), .SUB_CLOCK(sub_clk), .TIMER_OUT(tout), .TIMER_OUT_EN(ten));
	pt_pin_model pin (.clk(CLK), .out_lvl(tout), .out_en(ten), .ext_pin(ext_pin),
		.sub_clk(sub_clk), .pin_wire(pin_wire));

	task automatic stop_test;
		if (mismatches == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic wb(input logic we, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge CLK);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: {24'h0, d}};
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			stop_test();
		end
		q = dat_o[7:0];
		req <= '0;
		@(posedge CLK);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] q);
		wb(1'b0, a, 8'h00, q);
	endtask

	task automatic t_regs;
		logic [7:0] q;
		for (int a = 0; a < 10; a++) begin
			rd(6'(a * 4), q);
			`CHK("reset value", 8'h00, q)
		end
		wr(PT_ADR_CTRL0, 8'h07);
		rd(PT_ADR_CTRL0, q);
		`CHK("ctrl0 low bits", 8'h00, q)
		for (int i = 0; i < 4; i++) wr(PT_ADR_CMPAL + 6'(4 * i), 8'h5a ^ 8'(i));
		for (int i = 0; i < 4; i++) begin
			rd(PT_ADR_CMPAL + 6'(4 * i), q);
			`CHK("compare readback", 8'h5a ^ 8'(i), q)
		end
	endtask

	task automatic t_rate;
		int         dv [4] = '{4, 1, 16, 64};
		logic [2:0] ck;
		logic [7:0] v;
		logic [7:0] w;
		for (int i = 0; i < 4; i++) begin
			ck = 3'(i);
			wr(PT_ADR_CTRL0, {1'b1, ck, 4'h0});
			wr(PT_ADR_CTRL0, {1'b1, ck, 4'h8});
			rd(PT_ADR_CNTL, v);
			`CHK("count cleared", 8'h00, v)
			wr(PT_ADR_CTRL0, {1'b0, ck, 4'h8});
			repeat (10 * dv[i]) @(posedge CLK);
			wr(PT_ADR_CTRL0, {1'b1, ck, 4'h8});
			rd(PT_ADR_CNTL, v);
			`CHK("count rate", 1'b1, v inside {[9:15]})
			repeat (20) @(posedge CLK);
			rd(PT_ADR_CNTL, w);
			`CHK("count held", v, w)
			wr(PT_ADR_CTRL0, {1'b0, ck, 4'h8});
			repeat (2 * dv[i] + 8) @(posedge CLK);
			wr(PT_ADR_CTRL0, {1'b0, ck, 4'h0});
			rd(PT_ADR_CNTL, w);
			`CHK("count resumed", 1'b1, w > v)
			wr(PT_ADR_CNTL, 8'hff);
			rd(PT_ADR_CNTL, v);
			`CHK("count kept off", w, v)
		end
	endtask

	task automatic t_ext;
		logic [7:0] q;
		wr(PT_ADR_CTRL1, 8'hc0);
		wr(PT_ADR_PERL, 8'h00);
		wr(PT_ADR_PERH, 8'h00);
		for (int c = 4; c < 8; c++) begin
			wr(PT_ADR_CTRL0, {1'b0, 3'(c), 4'h8});
			pin.pulse(5, c < 6);
			rd(PT_ADR_CNTL, q);
			`CHK("source ticks", 8'h05, q)
			wr(PT_ADR_CTRL0, 8'h00);
		end
		wr(PT_ADR_PERL, 8'h03);
		wr(PT_ADR_FLAGS, 8'h03);
		wr(PT_ADR_CTRL0, 8'h68);
		pin.pulse(4, 1'b0);
		rd(PT_ADR_CNTL, q);
		`CHK("period clear", 8'h00, q)
		rd(PT_ADR_FLAGS, q);
		`CHK("period flag", 1'b1, q[PT_FL_P])
		wr(PT_ADR_CTRL0, 8'h00);
		wr(PT_ADR_CTRL1, 8'hc1);
		wr(PT_ADR_CMPAL, 8'h02);
		wr(PT_ADR_CMPAH, 8'h00);
		wr(PT_ADR_FLAGS, 8'h03);
		wr(PT_ADR_CTRL0, 8'h68);
		pin.pulse(3, 1'b0);
		rd(PT_ADR_CNTL, q);
		`CHK("compare clear", 8'h00, q)
		rd(PT_ADR_FLAGS, q);
		`CHK("flags after A", 2'b01, q[1:0])
	endtask

	task automatic t_pin;
		logic [10:0] tb [12] = '{{8'h09, 3'b111}, {8'h19, 3'b101}, {8'h21, 3'b011},
			{8'h31, 3'b011}, {8'h29, 3'b111}, {8'h25, 3'b101}, {8'h88, 3'b001},
			{8'h98, 3'b111}, {8'hb8, 3'b101}, {8'ha8, 3'b101}, {8'hc1, 3'b110},
			{8'h41, 3'b110}};
		for (int i = 0; i < 12; i++) begin
			wr(PT_ADR_CTRL0, 8'h00);
			wr(PT_ADR_CTRL1, tb[i][10:3]);
			wr(PT_ADR_CTRL0, 8'h68);
			repeat (4) @(posedge CLK);
			`CHK("pin start", tb[i][2], pin_wire)
			`CHK("pin enable", tb[i][0], ten)
			pin.pulse(3, 1'b0);
			`CHK("pin on match", tb[i][1], pin_wire)
		end
	endtask

	initial begin
		repeat (20) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		t_regs();
		t_rate();
		t_ext();
		t_pin();
		stop_test();
	end
endmodule

// File: tb/pt_pin_model.sv
// far-side model: external clock pin, sub clock source and the output pin wire
module pt_pin_model (
	input  wire logic clk,
	input  wire logic out_lvl,
	input  wire logic out_en,
	output logic      ext_pin,
	output logic      sub_clk,
	output logic      pin_wire
);
	timeunit 1ns;
	timeprecision 1ns;

	// both sources stand low between pulses
	initial begin
		ext_pin = 1'b0;
		sub_clk = 1'b0;
	end

	// released pin is pulled up
	assign pin_wire = out_en ? out_lvl : 1'b1;

	task automatic pulse(input int n, input bit sub);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk);
			if (sub) sub_clk <= 1'b1;
			else ext_pin <= 1'b1;
			repeat (4) @(posedge clk);
			sub_clk <= 1'b0;
			ext_pin <= 1'b0;
		end
		// let the synchroniser and pin logic settle
		repeat (8) @(posedge clk);
	endtask
endmodule
